// ---- core/ddcr_pkg.sv ----
// constants shared by the datapath configuration bank and its serial port
package ddcr_pkg;
    // ********************************
    // address map
    // ********************************
    localparam int ADDR_W = 7;
    localparam logic [6:0] ADDR_FHB_CTRL = 7'h1C;
    localparam logic [6:0] ADDR_SHB_CTRL = 7'h1D;
    localparam logic [6:0] ADDR_DP_CONFIG = 7'h1E;
    localparam logic [6:0] ADDR_PART_ID = 7'h1F;
    localparam logic [6:0] ADDR_I_PHASE_LOW = 7'h38;
    localparam logic [6:0] ADDR_I_PHASE_HIGH = 7'h39;
    localparam logic [6:0] ADDR_Q_PHASE_LOW = 7'h3A;
    localparam logic [6:0] ADDR_Q_PHASE_HIGH = 7'h3B;
    localparam logic [6:0] ADDR_I_OFS_LOW = 7'h3C;
    localparam logic [6:0] ADDR_I_OFS_HIGH = 7'h3D;
    localparam logic [6:0] ADDR_Q_OFS_LOW = 7'h3E;
    localparam logic [6:0] ADDR_Q_OFS_HIGH = 7'h3F;
    localparam logic [6:0] ADDR_I_FS_LOW = 7'h40;
    localparam logic [6:0] ADDR_I_CONV_CTRL = 7'h41;
    localparam logic [6:0] ADDR_I_AUX_LOW = 7'h42;
    localparam logic [6:0] ADDR_I_AUX_CTRL = 7'h43;
    localparam logic [6:0] ADDR_Q_FS_LOW = 7'h44;
    // ********************************
    // field positions
    // ********************************
    localparam int HB_SKIP_BIT = 0;
    localparam int FHB_MODE_LSB = 1;
    localparam int SHB_MODE_LSB = 1;
    localparam int DP_ENABLE_BIT = 0;
    localparam int SLEEP_BIT = 7;
    localparam int AUX_SIGN_BIT = 7;
    localparam int AUX_DIR_BIT = 6;
    localparam int AUX_SLEEP_BIT = 5;
    localparam int READ_FLAG_BIT = 7;
    localparam logic [5:0] SHB_LAST_PLAIN = 6'h1B;
    localparam logic [5:0] SHB_FIRST_MOD = 6'h24;
    // ********************************
    // reset values
    // ********************************
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [9:0] RST_FULL_SCALE = 10'h1F9;
    localparam logic [7:0] RST_Q_FS_LOW = 8'hF9;
endpackage : ddcr_pkg

// ---- core/ddcr_cfg_if.sv ----
// register access strobes between serial port and register bank
`timescale 1ns/100ps
interface ddcr_cfg_if;
    logic wr_en;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport port (output wr_en, output addr, output wdata, input rdata);
    modport bank (input wr_en, input addr, input wdata, output rdata);
endinterface : ddcr_cfg_if

// ---- core/ddcr_serial_port.sv ----
// serial configuration port: pins sampled on the core clock
`timescale 1ns/100ps
module ddcr_serial_port
    import ddcr_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_sclk_i,
    input wire logic spi_sdi_i,
    output logic spi_sdo_o,
    output logic spi_sdo_oe_o,
    ddcr_cfg_if.port bus
);
    typedef enum logic [1:0] {SP_IDLE, SP_INSTR, SP_DATA} ddcr_phase_e;
    typedef struct packed {
        logic [1:0] cs_sync;
        logic [1:0] sclk_sync;
        logic [1:0] sdi_sync;
        logic sclk_prev;
        ddcr_phase_e phase;
        logic [2:0] bit_cnt;
        logic [7:0] shift;
        logic [7:0] out_shift;
        logic is_read;
        logic load_pend;
        logic wr_en;
        logic [6:0] addr;
        logic [7:0] wdata;
        logic sdo_oe;
    } ddcr_sp_s;

    ddcr_sp_s st;
    ddcr_sp_s next_st;
    logic rise;
    logic fall;

    // ********************************
    // transaction engine
    // ********************************
    always_comb begin
        next_st = st;
        next_st.cs_sync = {st.cs_sync[0], spi_cs_n_i};
        next_st.sclk_sync = {st.sclk_sync[0], spi_sclk_i};
        next_st.sdi_sync = {st.sdi_sync[0], spi_sdi_i};
        next_st.sclk_prev = st.sclk_sync[1];
        next_st.wr_en = 1'b0;
        next_st.load_pend = 1'b0;
        rise = st.sclk_sync[1] && !st.sclk_prev;
        fall = !st.sclk_sync[1] && st.sclk_prev;
        if (st.wr_en) begin
            next_st.addr = st.addr + 7'h01;
        end
        if (st.load_pend) begin
            next_st.out_shift = bus.rdata;
        end
        if (st.cs_sync[1]) begin
            next_st.phase = SP_IDLE;
            next_st.bit_cnt = 3'h0;
        end else if (st.phase == SP_IDLE) begin
            next_st.phase = SP_INSTR;
            next_st.bit_cnt = 3'h0;
        end else if (rise) begin
            next_st.shift = {st.shift[6:0], st.sdi_sync[1]};
            next_st.bit_cnt = st.bit_cnt + 3'h1;
            if (st.bit_cnt == 3'h7) begin
                if (st.phase == SP_INSTR) begin
                    next_st.phase = SP_DATA;
                    next_st.is_read = st.shift[READ_FLAG_BIT - 1];
                    next_st.addr = {st.shift[5:0], st.sdi_sync[1]};
                    next_st.load_pend = st.shift[READ_FLAG_BIT - 1];
                end else if (st.is_read) begin
                    next_st.addr = st.addr + 7'h01;
                    next_st.load_pend = 1'b1;
                end else begin
                    next_st.wr_en = 1'b1;
                    next_st.wdata = {st.shift[6:0], st.sdi_sync[1]};
                end
            end
        end else if (fall && st.phase == SP_DATA && st.is_read && st.bit_cnt != 3'h0) begin
            next_st.out_shift = {st.out_shift[6:0], 1'b0};
        end
        next_st.sdo_oe = !st.cs_sync[1] && st.phase == SP_DATA && st.is_read;
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st <= '{cs_sync: 2'b11, phase: SP_IDLE, default: '0};
        end else begin
            st <= next_st;
        end
    end

    assign bus.wr_en = st.wr_en;
    assign bus.addr = st.addr;
    assign bus.wdata = st.wdata;
    assign spi_sdo_o = st.out_shift[7];
    assign spi_sdo_oe_o = st.sdo_oe;
endmodule : ddcr_serial_port

// ---- core/ddcr_top.sv ----
// datapath configuration register bank with sample offset adders
//
// Functional notes
// - first halfband modes 10/11: modulated, upper band
// - first halfband modes 00/01: unmodulated, centred/shifted
// - first halfband skip bit removes first filter
// - second halfband mode bits 6:1, plain to 011011
// - second halfband codes 100100 up are modulated
// - second halfband skip bit removes second filter
// - read-only eight-bit part identifier
// - ten-bit i phase word, two bytes
// - ten-bit q phase word, resets zero
// - sixteen-bit i offset added to samples
// - sixteen-bit q offset added to samples
// - ten-bit i full-scale trim code
// - bit 7 puts i converter asleep
// - aux bit 7 selects output sign
// - aux bit 6 selects source or sink
// - aux bit 5 puts aux source asleep
// - ten-bit i aux magnitude, linear
// - q trim low byte resets 11111001
`timescale 1ns/100ps
module ddcr_top
    import ddcr_pkg::*;
#(
    parameter logic [7:0] PART_CODE = 8'h5A, // arbitrary identification value
    parameter int SAMPLE_W = 16
) (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_sclk_i,
    input wire logic spi_sdi_i,
    output logic spi_sdo_o,
    output logic spi_sdo_oe_o,
    input wire logic [SAMPLE_W-1:0] i_sample_i,
    input wire logic [SAMPLE_W-1:0] q_sample_i,
    output logic [SAMPLE_W-1:0] i_sample_o,
    output logic [SAMPLE_W-1:0] q_sample_o,
    output logic [1:0] first_halfband_mode_o,
    output logic first_halfband_upper_o,
    output logic first_halfband_skip_o,
    output logic [5:0] second_halfband_mode_o,
    output logic second_halfband_modulated_o,
    output logic second_halfband_skip_o,
    output logic datapath_enable_o,
    output logic [9:0] i_phase_adjust_o,
    output logic [9:0] q_phase_adjust_o,
    output logic [9:0] i_full_scale_trim_o,
    output logic i_converter_sleep_o,
    output logic i_aux_sign_o,
    output logic i_aux_sink_o,
    output logic i_aux_sleep_o,
    output logic [9:0] i_aux_magnitude_o,
    output logic [7:0] q_full_scale_trim_low_o
);
    typedef struct packed {
        logic [1:0] fhb_mode;
        logic fhb_skip;
        logic [5:0] shb_mode;
        logic shb_skip;
        logic dp_enable;
        logic [9:0] i_phase;
        logic [9:0] q_phase;
        logic [15:0] i_offset;
        logic [15:0] q_offset;
        logic [9:0] i_fs;
        logic i_sleep;
        logic aux_sign;
        logic aux_sink;
        logic aux_sleep;
        logic [9:0] aux_mag;
        logic [7:0] q_fs_low;
        logic [SAMPLE_W-1:0] i_out;
        logic [SAMPLE_W-1:0] q_out;
    } ddcr_bank_s;

    ddcr_bank_s st;
    ddcr_bank_s next_st;
    logic [SAMPLE_W-1:0] i_sum;
    logic [SAMPLE_W-1:0] q_sum;
    logic [7:0] rdata;

    ddcr_cfg_if bus ();

    ddcr_serial_port u_port (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .spi_cs_n_i(spi_cs_n_i),
        .spi_sclk_i(spi_sclk_i),
        .spi_sdi_i(spi_sdi_i),
        .spi_sdo_o(spi_sdo_o),
        .spi_sdo_oe_o(spi_sdo_oe_o),
        .bus(bus)
    );

    // ********************************
    // decode helpers
    // ********************************
    function automatic logic shb_modulated(input logic [5:0] code);
        return code >= SHB_FIRST_MOD;
    endfunction : shb_modulated

    function automatic logic [7:0] high_pair(input logic [9:0] word);
        return {6'h00, word[9:8]};
    endfunction : high_pair

    // ********************************
    // register writes and sample path
    // ********************************
    always_comb begin
        next_st = st;
        i_sum = SAMPLE_W'(i_sample_i + st.i_offset);
        q_sum = SAMPLE_W'(q_sample_i + st.q_offset);
        next_st.i_out = i_sum;
        next_st.q_out = q_sum;
        if (bus.wr_en) begin
            unique case (bus.addr)
                ADDR_FHB_CTRL: begin
                    next_st.fhb_mode = bus.wdata[FHB_MODE_LSB +: 2];
                    next_st.fhb_skip = bus.wdata[HB_SKIP_BIT];
                end
                ADDR_SHB_CTRL: begin
                    next_st.shb_mode = bus.wdata[SHB_MODE_LSB +: 6];
                    next_st.shb_skip = bus.wdata[HB_SKIP_BIT];
                end
                ADDR_DP_CONFIG: next_st.dp_enable = bus.wdata[DP_ENABLE_BIT];
                ADDR_I_PHASE_LOW: next_st.i_phase[7:0] = bus.wdata;
                ADDR_I_PHASE_HIGH: next_st.i_phase[9:8] = bus.wdata[1:0];
                ADDR_Q_PHASE_LOW: next_st.q_phase[7:0] = bus.wdata;
                ADDR_Q_PHASE_HIGH: next_st.q_phase[9:8] = bus.wdata[1:0];
                ADDR_I_OFS_LOW: next_st.i_offset[7:0] = bus.wdata;
                ADDR_I_OFS_HIGH: next_st.i_offset[15:8] = bus.wdata;
                ADDR_Q_OFS_LOW: next_st.q_offset[7:0] = bus.wdata;
                ADDR_Q_OFS_HIGH: next_st.q_offset[15:8] = bus.wdata;
                ADDR_I_FS_LOW: next_st.i_fs[7:0] = bus.wdata;
                ADDR_I_CONV_CTRL: begin
                    next_st.i_sleep = bus.wdata[SLEEP_BIT];
                    next_st.i_fs[9:8] = bus.wdata[1:0];
                end
                ADDR_I_AUX_LOW: next_st.aux_mag[7:0] = bus.wdata;
                ADDR_I_AUX_CTRL: begin
                    next_st.aux_sign = bus.wdata[AUX_SIGN_BIT];
                    next_st.aux_sink = bus.wdata[AUX_DIR_BIT];
                    next_st.aux_sleep = bus.wdata[AUX_SLEEP_BIT];
                    next_st.aux_mag[9:8] = bus.wdata[1:0];
                end
                ADDR_Q_FS_LOW: next_st.q_fs_low = bus.wdata;
                default: next_st.i_out = i_sum;
            endcase
        end
    end

    // ********************************
    // readback, undefined bits as zero
    // ********************************
    always_comb begin
        rdata = RST_ZERO;
        unique case (bus.addr)
            ADDR_FHB_CTRL: rdata = {5'h00, st.fhb_mode, st.fhb_skip};
            ADDR_SHB_CTRL: rdata = {1'b0, st.shb_mode, st.shb_skip};
            ADDR_DP_CONFIG: rdata = {7'h00, st.dp_enable};
            ADDR_PART_ID: rdata = PART_CODE;
            ADDR_I_PHASE_LOW: rdata = st.i_phase[7:0];
            ADDR_I_PHASE_HIGH: rdata = high_pair(st.i_phase);
            ADDR_Q_PHASE_LOW: rdata = st.q_phase[7:0];
            ADDR_Q_PHASE_HIGH: rdata = high_pair(st.q_phase);
            ADDR_I_OFS_LOW: rdata = st.i_offset[7:0];
            ADDR_I_OFS_HIGH: rdata = st.i_offset[15:8];
            ADDR_Q_OFS_LOW: rdata = st.q_offset[7:0];
            ADDR_Q_OFS_HIGH: rdata = st.q_offset[15:8];
            ADDR_I_FS_LOW: rdata = st.i_fs[7:0];
            ADDR_I_CONV_CTRL: rdata = {st.i_sleep, 5'h00, st.i_fs[9:8]};
            ADDR_I_AUX_LOW: rdata = st.aux_mag[7:0];
            ADDR_I_AUX_CTRL: rdata = {st.aux_sign, st.aux_sink, st.aux_sleep, 3'h0, st.aux_mag[9:8]};
            ADDR_Q_FS_LOW: rdata = st.q_fs_low;
            default: rdata = RST_ZERO;
        endcase
    end

    assign bus.rdata = rdata;

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st <= '{i_fs: RST_FULL_SCALE, q_fs_low: RST_Q_FS_LOW, default: '0};
        end else begin
            st <= next_st;
        end
    end

    // ********************************
    // outputs
    // ********************************
    assign first_halfband_mode_o = st.fhb_mode;
    assign first_halfband_upper_o = st.fhb_mode[1];
    assign first_halfband_skip_o = st.fhb_skip;
    assign second_halfband_mode_o = st.shb_mode;
    assign second_halfband_modulated_o = shb_modulated(st.shb_mode);
    assign second_halfband_skip_o = st.shb_skip;
    assign datapath_enable_o = st.dp_enable;
    assign i_phase_adjust_o = st.i_phase;
    assign q_phase_adjust_o = st.q_phase;
    assign i_full_scale_trim_o = st.i_fs;
    assign i_converter_sleep_o = st.i_sleep;
    assign i_aux_sign_o = st.aux_sign;
    assign i_aux_sink_o = st.aux_sink;
    assign i_aux_sleep_o = st.aux_sleep;
    assign i_aux_magnitude_o = st.aux_mag;
    assign q_full_scale_trim_low_o = st.q_fs_low;
    assign i_sample_o = st.i_out;
    assign q_sample_o = st.q_out;

    // ********************************
    // assertions
    // ********************************
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);

    sequence s_write(logic [6:0] a);
        bus.wr_en && bus.addr == a;
    endsequence

    property p_fhb_upper;
        s_write(ADDR_FHB_CTRL) ##0 bus.wdata[2] |=> first_halfband_upper_o ##1 first_halfband_upper_o;
    endproperty
    a_fhb_upper: assert property (p_fhb_upper) else $error("fhb upper band not selected");

    property p_fhb_plain;
        s_write(ADDR_FHB_CTRL) ##0 !bus.wdata[2] |=> !first_halfband_upper_o && first_halfband_mode_o[1] == 1'b0;
    endproperty
    a_fhb_plain: assert property (p_fhb_plain) else $error("fhb plain mode shows modulated");

    property p_fhb_skip;
        s_write(ADDR_FHB_CTRL) |=> first_halfband_skip_o == $past(bus.wdata[0]);
    endproperty
    a_fhb_skip: assert property (p_fhb_skip) else $error("fhb skip not taken");

    property p_shb_plain;
        s_write(ADDR_SHB_CTRL) ##0 bus.wdata[6:1] <= SHB_LAST_PLAIN |=> !second_halfband_modulated_o;
    endproperty
    a_shb_plain: assert property (p_shb_plain) else $error("shb plain code shows modulated");

    property p_shb_mod;
        s_write(ADDR_SHB_CTRL) ##0 bus.wdata[6:1] >= SHB_FIRST_MOD |=> second_halfband_modulated_o;
    endproperty
    a_shb_mod: assert property (p_shb_mod) else $error("shb modulated code not flagged");

    property p_shb_skip;
        s_write(ADDR_SHB_CTRL) |=> second_halfband_skip_o == $past(bus.wdata[0]);
    endproperty
    a_shb_skip: assert property (p_shb_skip) else $error("shb skip not taken");

    property p_part_code;
        bus.addr == ADDR_PART_ID |-> bus.rdata == PART_CODE;
    endproperty
    a_part_code: assert property (p_part_code) else $error("part code readback wrong");

    property p_i_offset;
        ##1 i_sample_o == SAMPLE_W'($past(i_sample_i) + {$past(st.i_offset[15:8]), $past(st.i_offset[7:0])});
    endproperty
    a_i_offset: assert property (p_i_offset) else $error("i sample offset wrong");

    property p_q_offset;
        s_write(ADDR_Q_OFS_HIGH) |=> ##1 q_sample_o == SAMPLE_W'($past(q_sample_i) + st.q_offset);
    endproperty
    a_q_offset: assert property (p_q_offset) else $error("q sample offset wrong");

    property p_i_sleep;
        s_write(ADDR_I_CONV_CTRL) |=> i_converter_sleep_o == $past(bus.wdata[7]) && i_full_scale_trim_o[9:8] == $past(bus.wdata[1:0]);
    endproperty
    a_i_sleep: assert property (p_i_sleep) else $error("i converter control not taken");

    property p_aux_ctrl;
        s_write(ADDR_I_AUX_CTRL) |=> {i_aux_sign_o, i_aux_sink_o, i_aux_sleep_o} == $past(bus.wdata[7:5]);
    endproperty
    a_aux_ctrl: assert property (p_aux_ctrl) else $error("aux control not taken");

    property p_reserved_zero;
        bus.addr == ADDR_I_PHASE_HIGH || bus.addr == ADDR_Q_PHASE_HIGH |-> bus.rdata[7:2] == 6'h00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("undefined bits read nonzero");

    property p_dp_enable;
        s_write(ADDR_DP_CONFIG) |=> datapath_enable_o == $past(bus.wdata[0]);
    endproperty
    a_dp_enable: assert property (p_dp_enable) else $error("configuration bit not taken");

    property p_fhb_mode;
        s_write(ADDR_FHB_CTRL) |=> first_halfband_mode_o == $past(bus.wdata[FHB_MODE_LSB +: 2]);
    endproperty
    a_fhb_mode: assert property (p_fhb_mode) else $error("fhb mode not taken");

    property p_shb_mode;
        s_write(ADDR_SHB_CTRL) |=> second_halfband_mode_o == $past(bus.wdata[SHB_MODE_LSB +: 6]);
    endproperty
    a_shb_mode: assert property (p_shb_mode) else $error("shb mode not taken");

    property p_i_phase_low;
        s_write(ADDR_I_PHASE_LOW) |=> i_phase_adjust_o[7:0] == $past(bus.wdata);
    endproperty
    a_i_phase_low: assert property (p_i_phase_low) else $error("i phase low not taken");

    property p_i_phase_high;
        s_write(ADDR_I_PHASE_HIGH) |=> i_phase_adjust_o[9:8] == $past(bus.wdata[1:0]);
    endproperty
    a_i_phase_high: assert property (p_i_phase_high) else $error("i phase high not taken");

    property p_q_phase_low;
        s_write(ADDR_Q_PHASE_LOW) |=> q_phase_adjust_o[7:0] == $past(bus.wdata);
    endproperty
    a_q_phase_low: assert property (p_q_phase_low) else $error("q phase low not taken");

    property p_q_phase_high;
        s_write(ADDR_Q_PHASE_HIGH) |=> q_phase_adjust_o[9:8] == $past(bus.wdata[1:0]);
    endproperty
    a_q_phase_high: assert property (p_q_phase_high) else $error("q phase high not taken");

    property p_i_fs_low;
        s_write(ADDR_I_FS_LOW) |=> i_full_scale_trim_o[7:0] == $past(bus.wdata);
    endproperty
    a_i_fs_low: assert property (p_i_fs_low) else $error("i trim low not taken");

    property p_aux_low;
        s_write(ADDR_I_AUX_LOW) |=> i_aux_magnitude_o[7:0] == $past(bus.wdata);
    endproperty
    a_aux_low: assert property (p_aux_low) else $error("aux magnitude low not taken");

    property p_aux_high;
        s_write(ADDR_I_AUX_CTRL) |=> i_aux_magnitude_o[9:8] == $past(bus.wdata[1:0]);
    endproperty
    a_aux_high: assert property (p_aux_high) else $error("aux magnitude high not taken");

    property p_aux_dir;
        s_write(ADDR_I_AUX_CTRL) |=> i_aux_sink_o == $past(bus.wdata[AUX_DIR_BIT]);
    endproperty
    a_aux_dir: assert property (p_aux_dir) else $error("aux direction not taken");

    property p_q_fs_low;
        s_write(ADDR_Q_FS_LOW) |=> q_full_scale_trim_low_o == $past(bus.wdata);
    endproperty
    a_q_fs_low: assert property (p_q_fs_low) else $error("q trim low not taken");

    property p_id_ignored;
        s_write(ADDR_PART_ID) |=> $stable(i_phase_adjust_o) && $stable(datapath_enable_o);
    endproperty
    a_id_ignored: assert property (p_id_ignored) else $error("identifier write changed a field");
endmodule : ddcr_top

// ---- bench/ddcr_host_model.sv ----
// host controller model for the serial configuration port
`timescale 1ns/100ps
module ddcr_host_model (
    input wire logic core_clk_i,
    input wire logic spi_sdo_i,
    input wire logic spi_sdo_oe_i,
    output logic spi_cs_n_o,
    output logic spi_sclk_o,
    output logic spi_sdi_o
);
    // ****************
    // frame timing
    // ****************
    localparam int HALF = 6;
    initial begin
        spi_cs_n_o = 1'b1;
        spi_sclk_o = 1'b0;
        spi_sdi_o = 1'b0;
    end
    // one byte, msb first, read bit taken at the rising clock
    task automatic shift_byte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            spi_sdi_o = tx[i];
            repeat (HALF) @(negedge core_clk_i);
            rx[i] = spi_sdo_oe_i & spi_sdo_i;
            spi_sclk_o = 1'b1;
            repeat (HALF) @(negedge core_clk_i);
            spi_sclk_o = 1'b0;
        end
    endtask : shift_byte
    task automatic frame(input logic [7:0] instr, input logic [7:0] data[$], output logic [7:0] last_rx);
        logic [7:0] rx;
        spi_cs_n_o = 1'b0;
        repeat (HALF) @(negedge core_clk_i);
        shift_byte(instr, rx);
        foreach (data[k]) begin
            shift_byte(data[k], last_rx);
        end
        repeat (HALF) @(negedge core_clk_i);
        spi_cs_n_o = 1'b1;
        // released data line flips to the inverse of its last bit
        spi_sdi_o = ~spi_sdi_o;
        repeat (2 * HALF) @(negedge core_clk_i);
    endtask : frame
    task automatic write_regs(input logic [6:0] addr, input logic [7:0] data[$]);
        logic [7:0] rx;
        frame({1'b0, addr}, data, rx);
    endtask : write_regs
    task automatic read_reg(input logic [6:0] addr, output logic [7:0] value);
        frame({1'b1, addr}, '{8'hA5}, value);
    endtask : read_reg
endmodule : ddcr_host_model

// ---- bench/tb_dac_datapath_config_regs.sv ----
// self-checking bench for the datapath configuration bank
`timescale 1ns/100ps
module tb_dac_datapath_config_regs;
    import ddcr_pkg::*;
    // ****************
    // signals and tables
    // ****************
    localparam logic [7:0] PART_CODE_TB = 8'hA7; // arbitrary identification value
    localparam int N = 18;
    localparam int LIMIT = 60000;
    localparam logic [6:0] T_ADDR [N] = '{ADDR_FHB_CTRL, ADDR_SHB_CTRL, ADDR_DP_CONFIG, ADDR_PART_ID,
        ADDR_I_PHASE_LOW, ADDR_I_PHASE_HIGH, ADDR_Q_PHASE_LOW, ADDR_Q_PHASE_HIGH, ADDR_I_OFS_LOW,
        ADDR_I_OFS_HIGH, ADDR_Q_OFS_LOW, ADDR_Q_OFS_HIGH, ADDR_I_FS_LOW, ADDR_I_CONV_CTRL,
        ADDR_I_AUX_LOW, ADDR_I_AUX_CTRL, ADDR_Q_FS_LOW, 7'h50};
    localparam logic [7:0] T_RST [N] = '{8'h00, 8'h00, 8'h00, PART_CODE_TB, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'hF9, 8'h01, 8'h00, 8'h00, 8'hF9, 8'h00};
    localparam logic [7:0] T_MSK [N] = '{8'h07, 8'h7F, 8'h01, 8'h00, 8'hFF, 8'h03, 8'hFF, 8'h03,
        8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h83, 8'hFF, 8'hE3, 8'hFF, 8'h00};
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic cs_n, sclk, sdi, sdo, sdo_oe;
    logic [15:0] i_smp = 16'h0000;
    logic [15:0] q_smp = 16'h0000;
    logic [15:0] i_out, q_out, ones;
    logic [1:0] fhb_mode;
    logic [5:0] shb_mode, code;
    logic fhb_upper, fhb_skip, shb_mod, shb_skip, dp_en, i_sleep, aux_sign, aux_sink, aux_sleep;
    logic [9:0] i_phase, q_phase, i_trim, aux_mag;
    logic [7:0] q_trim_low, rd, pat;
    int miscompares = 0;
    int checked = 0;
    int cycles = 0;
    always #50 core_clk = ~core_clk;
    ddcr_top #(
        .PART_CODE(PART_CODE_TB),
        .SAMPLE_W(16)
    ) u_dut (
        .core_clk_i(core_clk),
        .rstn_i(rstn),
        .spi_cs_n_i(cs_n),
        .spi_sclk_i(sclk),
        .spi_sdi_i(sdi),
        .spi_sdo_o(sdo),
        .spi_sdo_oe_o(sdo_oe),
        .i_sample_i(i_smp),
        .q_sample_i(q_smp),
        .i_sample_o(i_out),
        .q_sample_o(q_out),
        .first_halfband_mode_o(fhb_mode),
        .first_halfband_upper_o(fhb_upper),
        .first_halfband_skip_o(fhb_skip),
        .second_halfband_mode_o(shb_mode),
        .second_halfband_modulated_o(shb_mod),
        .second_halfband_skip_o(shb_skip),
        .datapath_enable_o(dp_en),
        .i_phase_adjust_o(i_phase),
        .q_phase_adjust_o(q_phase),
        .i_full_scale_trim_o(i_trim),
        .i_converter_sleep_o(i_sleep),
        .i_aux_sign_o(aux_sign),
        .i_aux_sink_o(aux_sink),
        .i_aux_sleep_o(aux_sleep),
        .i_aux_magnitude_o(aux_mag),
        .q_full_scale_trim_low_o(q_trim_low)
    );
    ddcr_host_model u_host (
        .core_clk_i(core_clk),
        .spi_sdo_i(sdo),
        .spi_sdo_oe_i(sdo_oe),
        .spi_cs_n_o(cs_n),
        .spi_sclk_o(sclk),
        .spi_sdi_o(sdi)
    );
    // ****************
    // checking and verdict
    // ****************
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic report_and_stop();
        if (miscompares == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            miscompares++;
            report_and_stop();
        end
    end
    // ****************
    // scenarios
    // ****************
    initial begin
        repeat (3) @(negedge core_clk);
        rstn = 1'b1;
        repeat (4) @(negedge core_clk);
        check("i_trim_reset", {6'h00, i_trim}, 16'h01F9);
        for (int k = 0; k < N; k++) begin
            u_host.read_reg(T_ADDR[k], rd);
            check("reset_value", {8'h00, rd}, {8'h00, T_RST[k]});
        end
        u_host.write_regs(ADDR_DP_CONFIG, '{8'h01});
        check("dp_enable", {15'h0000, dp_en}, 16'h0001);
        for (int p = 0; p < 2; p++) begin
            pat = (p == 0) ? 8'hFF : 8'h00;
            for (int k = 0; k < N; k++) begin
                u_host.write_regs(T_ADDR[k], '{pat});
                u_host.read_reg(T_ADDR[k], rd);
                check("readback", {8'h00, rd}, {8'h00, (T_MSK[k] != 8'h00) ? (pat & T_MSK[k]) : T_RST[k]});
            end
            ones = {16{pat[0]}};
            check("hb_skips", {14'h0000, fhb_skip, shb_skip}, ones & 16'h0003);
            check("i_phase", {6'h00, i_phase}, ones & 16'h03FF);
            check("q_phase", {6'h00, q_phase}, ones & 16'h03FF);
            check("i_trim", {6'h00, i_trim}, ones & 16'h03FF);
            check("i_sleep", {15'h0000, i_sleep}, ones & 16'h0001);
            check("aux_flags", {13'h0000, aux_sign, aux_sink, aux_sleep}, ones & 16'h0007);
            check("aux_mag", {6'h00, aux_mag}, ones & 16'h03FF);
            check("q_trim_low", {8'h00, q_trim_low}, ones & 16'h00FF);
        end
        u_host.write_regs(ADDR_DP_CONFIG, '{8'h01});
        check("dp_enable", {15'h0000, dp_en}, 16'h0001);
        for (int m = 0; m < 4; m++) begin
            u_host.write_regs(ADDR_FHB_CTRL, '{8'(m << 1)});
            check("fhb_mode", {14'h0000, fhb_mode}, 16'(m));
            check("fhb_upper", {15'h0000, fhb_upper}, 16'(m >> 1));
        end
        for (int m = 0; m < 8; m++) begin
            code = {m[2:0], m[2:0]};
            u_host.write_regs(ADDR_SHB_CTRL, '{{1'b0, code, 1'b1}});
            check("shb_mode", {10'h000, shb_mode}, {10'h000, code});
            check("shb_mod", {15'h0000, shb_mod}, 16'(m >> 2));
            check("shb_skip", {15'h0000, shb_skip}, 16'h0001);
        end
        u_host.write_regs(ADDR_I_PHASE_LOW, '{8'h5A, 8'hFE, 8'hC3, 8'h01});
        check("i_phase_burst", {6'h00, i_phase}, 16'h025A);
        check("q_phase_burst", {6'h00, q_phase}, 16'h01C3);
        u_host.write_regs(ADDR_I_OFS_LOW, '{8'h34, 8'h12, 8'hFF, 8'hFF});
        for (int k = 0; k < 4; k++) begin
            i_smp = 16'hEDCC + 16'(k * 16'h1111);
            q_smp = 16'(k + 1);
            @(negedge core_clk);
            check("i_sample", i_out, i_smp + 16'h1234);
            check("q_sample", q_out, q_smp + 16'hFFFF);
        end
        report_and_stop();
    end
endmodule : tb_dac_datapath_config_regs
